//--- shared/host_if_pkg.sv
/*
 * Shared constants and carrier types for the host bus pin-mode interface.
 * Assumes a single 25 MHz clock domain and an active-high asynchronous reset.
 */
package host_if_pkg;

	// host interface mode codes
	localparam logic [1:0] MODE_SEP_STROBE = 2'h0;
	localparam logic [1:0] MODE_DATA_STROBE = 2'h1;
	localparam logic [1:0] MODE_SPI = 2'h2;
	localparam logic [1:0] MODE_SERIAL_LINK = 2'h3;
	localparam int MODE_SERIAL_BIT = 1;

	// data pin field positions
	localparam int PLL_STRAP_LSB = 5;
	localparam int PLL_STRAP_MSB = 12;
	localparam int SER_CLK_PIN = 2;
	localparam int SER_IN_PIN = 1;
	localparam int SER_OUT_PIN = 0;

	// widths and reset values
	localparam int DATA_W = 16;
	localparam int ADDR_W = 10;
	localparam logic [7:0] PLL_STRAP_RST = 8'h00;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [9:0] ADDR_RST = 10'h000;
	localparam int SYNC_STAGES = 2;

	// straps captured during reset
	typedef struct packed {
		logic [1:0] host_if_select;
		logic bus_width_select;
		logic [7:0] pll_strap;
	} strap_t;

	// one register-file access request
	typedef struct packed {
		logic wr;
		logic [9:0] addr;
		logic [15:0] wdata;
		logic [1:0] lanes;
	} reg_req_t;

endpackage

//--- verilog/sync_bus.sv
/*
 * Two-stage synchroniser for a vector of asynchronous pin inputs.
 * Assumes each bit is independent; multi-bit values must be quasi-static.
 */
module sync_bus
	import host_if_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// refuse an empty vector at elaboration
	if (WIDTH < 1) begin : g_width_check
		$error("sync_bus width must be positive");
	end

	// first stage feeds only the second
	always_comb begin
		meta_next = async_i;
		sync_next = meta_reg;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;
endmodule

//--- verilog/host_bus_pin_mode_interface.sv
/*
 * Host attachment pin logic: strap capture, parallel strobe decode, byte lanes,
 * data bus drive control and serial pin routing.
 * Assumes all pins are asynchronous to mclk_i and a register file answers rd_data_i
 * combinationally for the request address.
 */
// Overview of operation
// - serial modes sample data pins 12..5 as strap bits 7..0.
// - mode 11 routes D2 clock, D1 data in, drives D0 data out.
// - mode 10 routes D2 clock, D1 data in, D0 data out as slave.
// - latch strobe high is address phase; address captured on falling edge.
// - separate-strobe read with select drives addressed register onto data bus.
// - separate-strobe write with select stores data bus into addressed register.
// - data-strobe mode uses direction select and strobe to time accesses.
// - width low gives 8-bit bus, high gives 16-bit word transfers.
// - 16-bit byte transfers chosen by address bit 0 and lane enable.
// - mode 00 separate-strobe, 01 data-strobe, 1x serial modes.
// - separate-strobe 16-bit: lane enable low selects upper byte; ignored at 8-bit.
// - data-strobe 16-bit: lane enable low selects lower byte; ignored at 8-bit.
// - chip select is active low; strobes ignored while it is high.
module host_bus_pin_mode_interface
	import host_if_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [1:0] host_if_select_i,
	input wire logic bus_width_select_i,
	input wire logic [9:0] addr_i,
	input wire logic [15:0] data_i,
	input wire logic addr_latch_i,
	input wire logic chip_sel_n_i,
	input wire logic rd_strobe_n_i,
	input wire logic wr_strobe_n_i,
	input wire logic lane_enable_n_i,
	input wire logic ser_od_mode_i,
	input wire logic ctrl_serial_out_i,
	input wire logic [15:0] rd_data_i,
	output logic [15:0] data_o,
	output logic [15:0] data_oe_o,
	output logic [1:0] host_if_select_o,
	output logic bus_width_select_o,
	output logic [7:0] pll_strap_o,
	output logic ctrl_serial_clock_o,
	output logic ctrl_serial_in_o,
	output logic req_valid_o,
	output reg_req_t req_o
);
	logic [1:0] im_s;
	logic dbw_s;
	logic [9:0] addr_s;
	logic [15:0] data_s;
	logic ale_s;
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic lane_n_s;

	// every pin passes two flip-flops
	sync_bus #(.WIDTH(2 + 1 + 10 + 16 + 5)) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i({host_if_select_i, bus_width_select_i, addr_i, data_i, addr_latch_i,
			chip_sel_n_i, rd_strobe_n_i, wr_strobe_n_i, lane_enable_n_i}),
		.sync_o({im_s, dbw_s, addr_s, data_s, ale_s, cs_n_s, rd_n_s, wr_n_s, lane_n_s})
	);

	// strap capture state
	strap_t strap_reg;
	strap_t strap_next;
	logic in_reset_reg;
	logic in_reset_next;
	logic [1:0] cap_cnt_reg;
	logic [1:0] cap_cnt_next;

	// capture window spans the sync chain refill, which restarts from zero after reset
	always_comb begin
		strap_next = strap_reg;
		in_reset_next = (cap_cnt_reg != 2'h0);
		cap_cnt_next = in_reset_next ? cap_cnt_reg - 2'h1 : 2'h0;
		if (in_reset_reg) begin
			strap_next.host_if_select = im_s;
			strap_next.bus_width_select = dbw_s;
			strap_next.pll_strap = data_s[PLL_STRAP_MSB:PLL_STRAP_LSB];
		end
	end

	// last capture on the third edge after release, once sync chain holds pin levels
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			strap_reg <= '{host_if_select: MODE_SEP_STROBE, bus_width_select: 1'b0,
				pll_strap: PLL_STRAP_RST};
			in_reset_reg <= 1'b1;
			cap_cnt_reg <= 2'(SYNC_STAGES);
		end else begin
			strap_reg <= strap_next;
			in_reset_reg <= in_reset_next;
			cap_cnt_reg <= cap_cnt_next;
		end
	end

	wire serial_mode = strap_reg.host_if_select[MODE_SERIAL_BIT];
	wire ds_mode = (strap_reg.host_if_select == MODE_DATA_STROBE);
	wire wide = strap_reg.bus_width_select;

	// bus access state machine
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} bus_state_t;

	bus_state_t state_reg;
	bus_state_t state_next;
	logic [9:0] alat_reg;
	logic [9:0] alat_next;
	logic ale_d_reg;
	logic ale_d_next;
	logic [15:0] dout_reg;
	logic [15:0] dout_next;
	logic [15:0] oe_reg;
	logic [15:0] oe_next;
	logic req_valid_reg;
	logic req_valid_next;
	reg_req_t req_reg;
	reg_req_t req_next;
	logic sclk_reg;
	logic sclk_next;
	logic sin_reg;
	logic sin_next;

	logic selected;
	logic rd_act;
	logic wr_act;
	logic [9:0] eff_addr;
	logic [1:0] lanes;

	always_comb begin
		selected = !cs_n_s && !serial_mode && !in_reset_reg;
		// data-strobe mode: rd strobe pin carries strobe, wr pin carries direction
		if (ds_mode) begin
			rd_act = selected && !rd_n_s && wr_n_s;
			wr_act = selected && !rd_n_s && !wr_n_s;
		end else begin
			rd_act = selected && !rd_n_s;
			wr_act = selected && !wr_n_s && rd_n_s;
		end
		// address from latch while strobe low, live pins while held high
		eff_addr = ale_s ? addr_s : alat_reg;
		// byte lanes: bit0 low lane, bit1 high lane
		if (!wide) begin
			lanes = 2'h1;
		end else if (ds_mode) begin
			unique case ({eff_addr[0], lane_n_s})
				2'h0: lanes = 2'h3;
				2'h1: lanes = 2'h2;
				2'h2: lanes = 2'h1;
				default: lanes = 2'h2;
			endcase
		end else begin
			unique case ({eff_addr[0], lane_n_s})
				2'h0: lanes = 2'h3;
				2'h1: lanes = 2'h1;
				2'h2: lanes = 2'h2;
				default: lanes = 2'h1;
			endcase
		end
	end

	// next-state for bus, drivers and serial routing
	always_comb begin
		state_next = state_reg;
		ale_d_next = ale_s;
		alat_next = alat_reg;
		dout_next = dout_reg;
		oe_next = 16'h0000;
		req_valid_next = 1'b0;
		req_next = req_reg;
		sclk_next = 1'b0;
		sin_next = 1'b0;
		if (ale_d_reg && !ale_s) begin
			alat_next = addr_s;
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (rd_act) begin
					state_next = ST_READ;
					req_valid_next = 1'b1;
					req_next = '{wr: 1'b0, addr: eff_addr, wdata: DATA_RST, lanes: lanes};
				end else if (wr_act) begin
					state_next = ST_WRITE;
				end
			end
			ST_READ: begin
				dout_next = rd_data_i;
				oe_next = {{8{req_reg.lanes[1] && wide}}, {8{req_reg.lanes[0]}}};
				if (!rd_act) begin
					state_next = ST_IDLE;
					oe_next = 16'h0000;
				end
			end
			ST_WRITE: begin
				// store at strobe end, data settled through the sync chain
				if (!wr_act) begin
					state_next = ST_IDLE;
					req_valid_next = 1'b1;
					req_next.wr = 1'b1;
					req_next.addr = eff_addr;
					req_next.lanes = lanes;
					req_next.wdata = data_s;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (serial_mode) begin
			state_next = ST_IDLE;
			oe_next = 16'h0000;
			sclk_next = data_s[SER_CLK_PIN];
			sin_next = data_s[SER_IN_PIN];
			dout_next = {15'h0000, ctrl_serial_out_i};
			// open drain drives only lows
			oe_next[SER_OUT_PIN] = ser_od_mode_i ? !ctrl_serial_out_i : 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			ale_d_reg <= 1'b1;
			alat_reg <= ADDR_RST;
			dout_reg <= DATA_RST;
			oe_reg <= 16'h0000;
			req_valid_reg <= 1'b0;
			req_reg <= '0;
			sclk_reg <= 1'b0;
			sin_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ale_d_reg <= ale_d_next;
			alat_reg <= alat_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			req_valid_reg <= req_valid_next;
			req_reg <= req_next;
			sclk_reg <= sclk_next;
			sin_reg <= sin_next;
		end
	end

	assign data_o = dout_reg;
	assign data_oe_o = oe_reg;
	assign host_if_select_o = strap_reg.host_if_select;
	assign bus_width_select_o = strap_reg.bus_width_select;
	assign pll_strap_o = strap_reg.pll_strap;
	assign ctrl_serial_clock_o = sclk_reg;
	assign ctrl_serial_in_o = sin_reg;
	assign req_valid_o = req_valid_reg;
	assign req_o = req_reg;

	// assertions
	sequence s_read_start;
		state_reg == ST_IDLE && rd_act;
	endsequence

	a_serial_no_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
		serial_mode |=> oe_reg[15:1] == 15'h0000)
		else $error("data drivers on in serial mode");
	a_idle_no_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg == ST_IDLE && !serial_mode && !in_reset_reg) |=> oe_reg == 16'h0000)
		else $error("data drivers on outside read");
	a_read_request: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_read_start |=> req_valid_reg && !req_reg.wr && state_reg == ST_READ)
		else $error("read not requested");
	a_write_store: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg == ST_WRITE && !wr_act) |=> req_valid_reg && req_reg.wr &&
		req_reg.wdata == $past(data_s))
		else $error("write not stored");
	a_cs_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
		(cs_n_s && state_reg == ST_IDLE) |=> !req_valid_reg)
		else $error("access taken without chip select");
	a_strap_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		!in_reset_reg |=> $stable(strap_reg))
		else $error("straps changed after reset");
	a_narrow_lane: assert property (@(posedge mclk_i) disable iff (rst_i)
		(req_valid_reg && !wide) |-> req_reg.lanes == 2'h1)
		else $error("8-bit access used upper lane");
	a_serial_route: assert property (@(posedge mclk_i) disable iff (rst_i)
		serial_mode |=> sclk_reg == $past(data_s[SER_CLK_PIN]) &&
		sin_reg == $past(data_s[SER_IN_PIN]))
		else $error("serial pins not routed");
	a_addr_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ale_d_reg && !ale_s) |=> alat_reg == $past(addr_s))
		else $error("address not latched on falling strobe");
endmodule

//--- dv/host_model.sv
/*
 * Host processor model: drives chip select, strobes, address and data pins.
 * Assumes the bench resolves the shared data wire and calls its tasks.
 */
module host_model
	import host_if_pkg::*;
(
	input wire logic mclk_i,
	input wire logic req_valid_i,
	input wire reg_req_t req_i,
	input wire logic [15:0] bus_i,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic lane_n_o,
	output logic ale_o,
	output logic [9:0] addr_o,
	output logic drv_o,
	output logic [15:0] wdat_o,
	output reg_req_t got_o,
	output logic [15:0] rdv_o,
	output logic late_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle pins; latch strobe held high for demultiplexed wiring
	initial begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		lane_n_o = 1'b1;
		ale_o = 1'b1;
		addr_o = 10'h000;
		drv_o = 1'b0;
		wdat_o = 16'h0000;
		got_o = '0;
		rdv_o = 16'h0000;
		late_o = 1'b0;
	end

	// wait for the request pulse, bounded
	task automatic wait_req();
		int n;
		n = 0;
		while (req_valid_i !== 1'b1 && n < 20) begin
			@(posedge mclk_i);
			#2;
			n++;
		end
		if (n == 20) begin
			late_o = 1'b1;
		end
		got_o = req_i;
	endtask

	// latch strobe level and address pins, then let the sync chain settle
	task automatic set_latch(input logic lvl, input logic [9:0] a);
		@(posedge mclk_i);
		#2;
		ale_o = lvl;
		addr_o = a;
		repeat (3) @(posedge mclk_i);
		#2;
	endtask

	// one parallel cycle; ds picks data-strobe mode
	task automatic access(input logic ds, input logic wr, input logic [9:0] a,
		input logic [15:0] d, input logic ln, input logic cs);
		@(posedge mclk_i);
		#2;
		cs_n_o = cs;
		addr_o = a;
		lane_n_o = ln;
		drv_o = wr;
		wdat_o = d;
		wr_n_o = !wr;
		rd_n_o = wr & !ds;
		if (cs) begin
			repeat (6) @(posedge mclk_i);
			#2;
		end else if (!wr) begin
			wait_req();
			@(posedge mclk_i);
			#2;
			rdv_o = bus_i;
		end else begin
			repeat (3) @(posedge mclk_i);
			#2;
		end
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		if (wr && !cs) begin
			wait_req();
		end
		cs_n_o = 1'b1;
		drv_o = 1'b0;
		repeat (4) @(posedge mclk_i);
		#2;
	endtask
endmodule

//--- dv/host_bus_pin_mode_interface_tb.sv
/*
 * Testbench: parallel accesses in all lane cases, chip select, straps, serial pins.
 * Assumes pull-ups on released data pins and a combinational register file.
 */
module host_bus_pin_mode_interface_tb;
	import host_if_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] mode = 2'h0;
	logic wide = 1'b1;
	logic ser_od = 1'b0;
	logic ser_out = 1'b0;
	logic [15:0] sval = 16'hFFFF;
	logic [15:0] data_o, data_oe, bus, wdat, rdv, rd_data;
	logic [1:0] sel_o;
	logic bw_o, sclk_o, sin_o, req_valid, cs_n, rd_n, wr_n, ln, ale, drv, late;
	logic [7:0] pll_o;
	logic [9:0] addr;
	reg_req_t req, got;
	int mismatches = 0;
	int total_checks = 0;
	int reqs = 0;
	int reqs_before = 0;
	logic [1:0] t00 [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
	logic [1:0] t01 [4] = '{2'h3, 2'h2, 2'h1, 2'h2};

	always #20 mclk_i = ~mclk_i;

	// released pins rise to the pull-up level
	assign bus = (data_oe & data_o) | (~data_oe & (drv ? wdat : sval));
	assign rd_data = {6'h00, req.addr} ^ 16'hA5C3;

	// count request pulses
	always @(posedge mclk_i) begin
		if (req_valid === 1'b1) begin
			reqs++;
		end
	end

	host_bus_pin_mode_interface dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.host_if_select_i(mode), .bus_width_select_i(wide), .addr_i(addr),
		.data_i(bus), .addr_latch_i(ale), .chip_sel_n_i(cs_n), .rd_strobe_n_i(rd_n),
		.wr_strobe_n_i(wr_n), .lane_enable_n_i(ln), .ser_od_mode_i(ser_od),
		.ctrl_serial_out_i(ser_out), .rd_data_i(rd_data), .data_o(data_o),
		.data_oe_o(data_oe), .host_if_select_o(sel_o), .bus_width_select_o(bw_o),
		.pll_strap_o(pll_o), .ctrl_serial_clock_o(sclk_o), .ctrl_serial_in_o(sin_o),
		.req_valid_o(req_valid), .req_o(req));

	host_model u_host (.mclk_i(mclk_i), .req_valid_i(req_valid), .req_i(req),
		.bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .lane_n_o(ln),
		.ale_o(ale), .addr_o(addr), .drv_o(drv), .wdat_o(wdat), .got_o(got),
		.rdv_o(rdv), .late_o(late));

	task automatic close_out();
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#2;
	endtask

	// reset with straps applied, then check the captured mode and width
	task automatic boot(input logic [1:0] m, input logic w, input logic [15:0] s);
		rst_i = 1'b1;
		mode = m;
		wide = w;
		sval = s;
		step(12);
		rst_i = 1'b0;
		step(4);
		chk("mode", 16'(sel_o), 16'(m));
		chk("width", 16'(bw_o), 16'(w));
	endtask

	// one access with the expected lane code
	task automatic rw(input logic ds, input logic wr, input logic [9:0] a,
		input logic [15:0] d, input logic n, input logic [1:0] lanes);
		logic [15:0] oe;
		oe = {{8{lanes[1]}}, {8{lanes[0]}}};
		u_host.access(ds, wr, a, d, n, 1'b0);
		if (late) begin
			mismatches++;
			close_out();
		end
		chk("dir", 16'(got.wr), 16'(wr));
		chk("addr", 16'(got.addr), 16'(a));
		chk("lanes", 16'(got.lanes), 16'(lanes));
		if (wr) begin
			chk("wdata", got.wdata, d);
		end else begin
			chk("rdata", rdv, (({6'h00, a} ^ 16'hA5C3) & oe) | ~oe);
		end
		chk("oe idle", data_oe, 16'h0000);
	endtask

	initial begin
		boot(MODE_SEP_STROBE, 1'b1, 16'hFFFF);
		for (int i = 0; i < 8; i++) begin
			rw(1'b0, i[2], 10'h2B4 | 10'(i[1]), 16'h1234 + 16'(i), i[0], t00[i[1:0]]);
		end
		reqs_before = reqs;
		u_host.access(1'b0, 1'b1, 10'h011, 16'h00FF, 1'b0, 1'b1);
		chk("cs high", 16'(reqs), 16'(reqs_before));
		chk("cs req", 16'(got.addr), 16'h02B5);
		u_host.set_latch(1'b1, 10'h0C7);
		u_host.set_latch(1'b0, 10'h0C7);
		u_host.access(1'b0, 1'b0, 10'h300, 16'h0000, 1'b1, 1'b0);
		chk("mux addr", 16'(got.addr), 16'h00C7);
		chk("mux rdata", rdv, 16'hFF04);
		u_host.set_latch(1'b1, 10'h000);
		boot(MODE_DATA_STROBE, 1'b1, 16'hFFFF);
		for (int i = 0; i < 8; i++) begin
			rw(1'b1, i[2], 10'h1C2 | 10'(i[1]), 16'hBE00 + 16'(i), i[0], t01[i[1:0]]);
		end
		boot(MODE_SEP_STROBE, 1'b0, 16'hFFFF);
		rw(1'b0, 1'b0, 10'h3F1, 16'h0000, 1'b0, 2'h1);
		rw(1'b0, 1'b1, 10'h3F1, 16'hC35A, 1'b0, 2'h1);
		ser_od = 1'b1;
		boot(MODE_SPI, 1'b0, 16'hF2DA);
		chk("strap", 16'(pll_o), 16'h0096);
		chk("spi oe", data_oe, 16'h0001);
		sval = 16'hF2DE;
		step(1);
		chk("spi clk", 16'(sclk_o), 16'h0000);
		step(3);
		chk("spi clk", 16'(sclk_o), 16'h0001);
		chk("spi in", 16'(sin_o), 16'h0001);
		ser_od = 1'b0;
		ser_out = 1'b1;
		boot(MODE_SERIAL_LINK, 1'b0, 16'hE798);
		chk("strap", 16'(pll_o), 16'h003C);
		chk("pp out", bus & data_oe, 16'h0001);
		ser_od = 1'b1;
		step(2);
		chk("od out", data_oe, 16'h0000);
		close_out();
	end
endmodule
